// ### include/sarrd_params.svh
`ifndef SARRD_PARAMS_SVH
`define SARRD_PARAMS_SVH

`define SARRD_CLK_NS 100
`define SARRD_DATA_BITS 16
`define SARRD_BUSY_EDGES 17
`define SARRD_CONV_MIN_NS 772
`define SARRD_CONV_TYP_NS 812
`define SARRD_CONV_MAX_NS 853
`define SARRD_CYC_MIN_NS 1666
`define SARRD_CNVH_MIN_NS 9
`define SARRD_SCK_MIN_NS 25
`define SARRD_CONV_CYC ((`SARRD_CONV_MIN_NS + `SARRD_CLK_NS - 1) / `SARRD_CLK_NS)
`define SARRD_CONV_MAX_CYC (`SARRD_CONV_MAX_NS / `SARRD_CLK_NS)
`define SARRD_CYC_CYC ((`SARRD_CYC_MIN_NS + `SARRD_CLK_NS - 1) / `SARRD_CLK_NS)
`define SARRD_CNVH_CYC ((`SARRD_CNVH_MIN_NS + `SARRD_CLK_NS - 1) / `SARRD_CLK_NS)
`define SARRD_SYNC_LAT 2
`define SARRD_POS_FS 16'h7FFF
`define SARRD_NEG_FS 16'h8000
`define SARRD_IRQ_TIMEOUT 8'hFF

`endif

// ### include/sarrd_pkg.sv
package sarrd_pkg;

	typedef enum logic [1:0] {
		SARRD_3W_PLAIN,
		SARRD_3W_BUSY,
		SARRD_4W_PLAIN
	} sarrd_mode_t;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_CONV,
		DEV_WAIT,
		DEV_SHIFT
	} sarrd_dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_CONV,
		H_IRQ,
		H_SEL,
		H_HIGH,
		H_LOW,
		H_END
	} sarrd_host_state_t;

endpackage

// ### include/sarrd_if.sv
`timescale 1ns/1ps
interface sarrd_if;
	logic conv_start;
	logic ser_sel;
	logic ser_clk;
	logic ser_out;
	logic ser_out_oe;
	logic ser_line;

	// Pull-up holds the line high while the output floats
	assign ser_line = ser_out_oe ? ser_out : 1'b1;

	modport dev (
		input conv_start,
		input ser_sel,
		input ser_clk,
		output ser_out,
		output ser_out_oe
	);

	modport host (
		output conv_start,
		output ser_sel,
		output ser_clk,
		input ser_line
	);
endinterface

// ### rtl/sarrd_device.sv
`timescale 1ns/1ps
`include "sarrd_params.svh"
// Overview of operation
// - Select level at start edge picks mode.
// - Result ready 772 to 853 ns after start.
// - Host spaces start edges 1666 ns apart.
// - Host holds start pulse high 9 ns.
// - Host serial clock period and phases bounded.
// - Start edge samples, converts, floats output.
// - Conversion finishes regardless of start pin.
// - Start high at end suppresses busy bit.
// - Start falling edge drives MSB, falls shift.
// - Host captures bits on serial clock fall.
// - Float after 16th fall or deselect.
// - Start low at end produces busy bit.
// - End of conversion drives low busy bit.
// - Busy read floats after 17th fall.
// - Select high at start edge, four-wire.
// - Four-wire host keeps start high throughout.
// - Start high at end suppresses busy bit; select low enables output.
// - Result coded in two's complement.
// - Busy bit optional, precedes result bits.
// - Capacitors reconnect after conversion ends.
// - Select falling edge drives MSB first.
// - Float after 16th fall or select high.
module sarrd_device
	import sarrd_pkg::*;
#(
	parameter int CONV_CYCLES = `SARRD_CONV_CYC
)
(
	input wire logic i_mclk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic signed [`SARRD_DATA_BITS+1:0] i_analog, // Input in steps
	output logic [`SARRD_DATA_BITS-1:0] o_result, // Last result
	output logic o_result_valid, // Result pulse
	output logic o_sampling, // Capacitors on input
	output logic o_chain_sel, // Unsupported chain mode seen
	output logic o_busy_sel, // Last read carries busy bit
	sarrd_if.dev lk // Link pins
);

	localparam int NB = `SARRD_DATA_BITS;
	// The start edge is acted on at the third clock edge after the pin
	localparam int RUN = CONV_CYCLES - `SARRD_SYNC_LAT - 1;

	generate
		if (CONV_CYCLES * `SARRD_CLK_NS < `SARRD_CONV_MIN_NS ||
			CONV_CYCLES * `SARRD_CLK_NS > `SARRD_CONV_MAX_NS ||
			RUN < 1)
		begin : g_bad
			$error("CONV_CYCLES outside conversion window");
		end
	endgenerate

	sarrd_dev_state_t state_reg;
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic [2:0] prev_reg;
	logic [3:0] conv_cnt_reg;
	logic [4:0] bit_cnt_reg;
	logic [NB:0] shift_reg;
	logic [NB-1:0] held_reg;
	logic oe_reg;
	logic samp_reg;
	logic busy_reg;
	logic chain_reg;
	logic [NB-1:0] result_reg;
	logic valid_reg;
	logic cnv_rise;
	logic sck_fall;
	logic active;
	logic conv_end;

	function automatic logic [NB-1:0] to_code(
		input logic signed [NB+1:0] v
	);
		logic signed [NB+1:0] pos;
		logic signed [NB+1:0] neg;
		pos = {2'b00, `SARRD_POS_FS};
		neg = {2'b11, `SARRD_NEG_FS};
		if (v > pos)
		begin
			to_code = `SARRD_POS_FS;
		end
		else if (v < neg)
		begin
			to_code = `SARRD_NEG_FS;
		end
		else
		begin
			to_code = v[NB-1:0];
		end
	endfunction

	// Pins: {serial clock, select, start}
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
			prev_reg <= 3'h0;
		end
		else
		begin
			meta_reg <= {lk.ser_clk, lk.ser_sel, lk.conv_start};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign cnv_rise = sync_reg[0] & ~prev_reg[0];
	assign sck_fall = ~sync_reg[2] & prev_reg[2];
	// Output selected while start or select is low
	assign active = ~(sync_reg[0] & sync_reg[1]);
	assign conv_end = (state_reg == DEV_CONV) &&
		(conv_cnt_reg == 4'(RUN - 1));

	// Sequencing
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_reg <= DEV_IDLE;
			conv_cnt_reg <= 4'h0;
			bit_cnt_reg <= 5'h00;
			oe_reg <= 1'b0;
		end
		else if (cnv_rise && state_reg != DEV_CONV)
		begin
			oe_reg <= 1'b0;
			conv_cnt_reg <= 4'h0;
			if (sync_reg[1])
			begin
				state_reg <= DEV_CONV;
			end
			else
			begin
				state_reg <= DEV_IDLE;
			end
		end
		else
		begin
			unique case (state_reg)
				DEV_IDLE:
				begin
					oe_reg <= 1'b0;
				end
				DEV_CONV:
				begin
					conv_cnt_reg <= conv_cnt_reg + 4'h1;
					if (conv_end)
					begin
						if (!sync_reg[0])
						begin
							state_reg <= DEV_SHIFT;
							bit_cnt_reg <= 5'(`SARRD_BUSY_EDGES);
							oe_reg <= 1'b1;
						end
						else
						begin
							state_reg <= DEV_WAIT;
							bit_cnt_reg <= 5'(NB);
						end
					end
				end
				DEV_WAIT:
				begin
					if (active)
					begin
						state_reg <= DEV_SHIFT;
						oe_reg <= 1'b1;
					end
				end
				DEV_SHIFT:
				begin
					if (!active)
					begin
						state_reg <= DEV_IDLE;
						oe_reg <= 1'b0;
					end
					else if (sck_fall)
					begin
						bit_cnt_reg <= bit_cnt_reg - 5'h01;
						if (bit_cnt_reg == 5'h01)
						begin
							state_reg <= DEV_IDLE;
							oe_reg <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// Sampling and output shift register
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			held_reg <= '0;
			shift_reg <= '0;
			samp_reg <= 1'b1;
			busy_reg <= 1'b0;
			chain_reg <= 1'b0;
		end
		else
		begin
			if (cnv_rise && state_reg != DEV_CONV)
			begin
				chain_reg <= ~sync_reg[1];
				if (sync_reg[1])
				begin
					held_reg <= to_code(i_analog);
					samp_reg <= 1'b0;
				end
			end
			else if (conv_end)
			begin
				samp_reg <= 1'b1;
				busy_reg <= ~sync_reg[0];
				if (!sync_reg[0])
				begin
					shift_reg <= {1'b0, held_reg};
				end
				else
				begin
					shift_reg <= {held_reg, 1'b0};
				end
			end
			else if (state_reg == DEV_SHIFT && active && sck_fall)
			begin
				shift_reg <= {shift_reg[NB-1:0], 1'b0};
			end
		end
	end

	// Completed result for the user side
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			result_reg <= '0;
			valid_reg <= 1'b0;
		end
		else
		begin
			valid_reg <= conv_end;
			if (conv_end)
			begin
				result_reg <= held_reg;
			end
		end
	end

	assign lk.ser_out = shift_reg[NB];
	assign lk.ser_out_oe = oe_reg;
	assign o_result = result_reg;
	assign o_result_valid = valid_reg;
	assign o_sampling = samp_reg;
	assign o_chain_sel = chain_reg;
	assign o_busy_sel = busy_reg;

endmodule // sarrd_device

// ### rtl/sarrd_host.sv
`timescale 1ns/1ps
`include "sarrd_params.svh"
module sarrd_host
	import sarrd_pkg::*;
#(
	parameter int HALF_SCK = 4,
	parameter int SETTLE = 4
)
(
	input wire logic i_mclk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic i_start, // Request one sample
	input wire sarrd_mode_t i_mode, // Interface option
	output logic o_ready, // Start may be taken
	output logic [`SARRD_DATA_BITS-1:0] o_data, // Read result
	output logic o_data_valid, // Result pulse
	output logic o_fault, // Busy bit never came
	sarrd_if.host lk // Link pins
);

	localparam int NB = `SARRD_DATA_BITS;
	localparam int WAIT = `SARRD_CONV_MAX_CYC + `SARRD_SYNC_LAT + 2;

	generate
		if (HALF_SCK < 4 || HALF_SCK > 100 || SETTLE < 3 ||
			SETTLE > 200 ||
			2 * HALF_SCK * `SARRD_CLK_NS < `SARRD_SCK_MIN_NS)
		begin : g_bad
			$error("HALF_SCK or SETTLE unusable");
		end
	endgenerate

	sarrd_host_state_t state_reg;
	sarrd_mode_t mode_reg;
	logic [7:0] timer_reg;
	logic [4:0] edge_reg;
	logic [4:0] gap_reg;
	logic [1:0] line_sync_reg;
	logic [NB-1:0] data_reg;
	logic cnv_reg;
	logic sel_reg;
	logic sck_reg;
	logic ready_reg;
	logic valid_reg;
	logic fault_reg;
	logic take;

	assign take = ready_reg && i_start;

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			line_sync_reg <= 2'h3;
		end
		else
		begin
			line_sync_reg <= {line_sync_reg[0], lk.ser_line};
		end
	end

	// Spacing between start edges
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			gap_reg <= 5'(`SARRD_CYC_CYC);
			ready_reg <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				gap_reg <= 5'h00;
			end
			else if (gap_reg != 5'(`SARRD_CYC_CYC))
			begin
				gap_reg <= gap_reg + 5'h01;
			end
			ready_reg <= !take && state_reg == H_IDLE &&
				gap_reg >= 5'(`SARRD_CYC_CYC - 1);
		end
	end

	// Link sequencing
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_reg <= H_IDLE;
			mode_reg <= SARRD_3W_PLAIN;
			timer_reg <= 8'h00;
			edge_reg <= 5'h00;
			cnv_reg <= 1'b0;
			sel_reg <= 1'b1;
			sck_reg <= 1'b0;
			data_reg <= '0;
			valid_reg <= 1'b0;
			fault_reg <= 1'b0;
		end
		else
		begin
			valid_reg <= 1'b0;
			timer_reg <= timer_reg + 8'h01;
			unique case (state_reg)
				H_IDLE:
				begin
					timer_reg <= 8'h00;
					if (take)
					begin
						mode_reg <= i_mode;
						cnv_reg <= 1'b1;
						fault_reg <= 1'b0;
						state_reg <= H_CONV;
					end
				end
				H_CONV:
				begin
					if (mode_reg == SARRD_3W_BUSY &&
						timer_reg == 8'(`SARRD_CNVH_CYC))
					begin
						cnv_reg <= 1'b0;
					end
					if (timer_reg == 8'(WAIT))
					begin
						timer_reg <= 8'h00;
						edge_reg <= 5'(NB);
						unique case (mode_reg)
							SARRD_3W_BUSY:
							begin
								edge_reg <= 5'(`SARRD_BUSY_EDGES);
								state_reg <= H_IRQ;
							end
							SARRD_4W_PLAIN:
							begin
								sel_reg <= 1'b0;
								state_reg <= H_SEL;
							end
							default:
							begin
								cnv_reg <= 1'b0;
								state_reg <= H_SEL;
							end
						endcase
					end
				end
				H_IRQ:
				begin
					if (!line_sync_reg[1])
					begin
						timer_reg <= 8'h00;
						state_reg <= H_SEL;
					end
					else if (timer_reg == `SARRD_IRQ_TIMEOUT)
					begin
						fault_reg <= 1'b1;
						state_reg <= H_END;
					end
				end
				H_SEL:
				begin
					if (timer_reg == 8'(SETTLE - 1))
					begin
						timer_reg <= 8'h00;
						sck_reg <= 1'b1;
						state_reg <= H_HIGH;
					end
				end
				H_HIGH:
				begin
					if (timer_reg == 8'(HALF_SCK - 1))
					begin
						// Capture at end of high phase
						data_reg <= {data_reg[NB-2:0], line_sync_reg[1]};
						timer_reg <= 8'h00;
						sck_reg <= 1'b0;
						edge_reg <= edge_reg - 5'h01;
						state_reg <= H_LOW;
					end
				end
				H_LOW:
				begin
					if (timer_reg == 8'(HALF_SCK - 1))
					begin
						timer_reg <= 8'h00;
						if (edge_reg == 5'h00)
						begin
							state_reg <= H_END;
						end
						else
						begin
							sck_reg <= 1'b1;
							state_reg <= H_HIGH;
						end
					end
				end
				H_END:
				begin
					cnv_reg <= 1'b0;
					sel_reg <= 1'b1;
					valid_reg <= !fault_reg;
					state_reg <= H_IDLE;
				end
				default:
				begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign lk.conv_start = cnv_reg;
	assign lk.ser_sel = sel_reg;
	assign lk.ser_clk = sck_reg;
	assign o_ready = ready_reg;
	assign o_data = data_reg;
	assign o_data_valid = valid_reg;
	assign o_fault = fault_reg;

endmodule // sarrd_host

// ### sim/sarrd_checker.sv
`timescale 1ns/1ps
`include "sarrd_params.svh"
module sarrd_checker (
	input wire logic i_mclk, // System clock
	input wire logic i_arst_n, // Async reset, active low
	input wire logic conv_start, // Start pin
	input wire logic ser_sel, // Select input
	input wire logic ser_clk, // Serial clock
	input wire logic ser_out, // Device data bit
	input wire logic ser_out_oe // Device drives line
);
	logic [4:0] falls_reg;
	logic [4:0] since_reg;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	// Cycles since the last start edge, saturating
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			since_reg <= 5'h1F;
		else if ($rose(conv_start))
			since_reg <= 5'h00;
		else if (since_reg != 5'h1F)
			since_reg <= since_reg + 5'h01;
	end
	// Serial clock falls seen within one enabled read
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			falls_reg <= 5'h00;
		else if (!ser_out_oe)
			falls_reg <= 5'h00;
		else if ($fell(ser_clk))
			falls_reg <= falls_reg + 5'h01;
	end
	property p_float_start;
		$rose(conv_start) && ser_sel |-> ##[1:4] !ser_out_oe;
	endproperty
	a_float_start: assert property (p_float_start)
		else $error("output not floated after start");
	property p_desel;
		(conv_start && ser_sel) [*4] |-> !ser_out_oe;
	endproperty
	a_desel: assert property (p_desel)
		else $error("output driven while deselected");
	property p_enable;
		$rose(ser_out_oe) |-> !conv_start || !ser_sel;
	endproperty
	a_enable: assert property (p_enable)
		else $error("output enabled without select");
	property p_conv_min;
		$rose(conv_start) |-> ##1 !$rose(ser_out_oe) [*7];
	endproperty
	a_conv_min: assert property (p_conv_min)
		else $error("output enabled before conversion end");
	property p_conv_run;
		$rose(conv_start) && ser_sel ##2 !conv_start
			|-> ##6 $rose(ser_out_oe);
	endproperty
	a_conv_run: assert property (p_conv_run)
		else $error("busy bit missing after conversion");
	property p_bit_hold;
		ser_out_oe && $past(ser_out_oe) && ser_clk && $past(ser_clk)
			|-> $stable(ser_out);
	endproperty
	a_bit_hold: assert property (p_bit_hold)
		else $error("data changed while serial clock high");
	property p_count;
		ser_out_oe |-> falls_reg <= 5'h11;
	endproperty
	a_count: assert property (p_count)
		else $error("output driven past last bit");
	property p_spacing;
		$rose(conv_start) |-> since_reg >= 5'(`SARRD_CYC_CYC - 1);
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("start edges too close");
endmodule // sarrd_checker

// ### sim/sar_adc_select_mode_readout_test.sv
`timescale 1ns/1ps
module sar_adc_select_mode_readout_test
	import sarrd_pkg::*;
;
	logic mclk;
	logic arst_n;
	logic start;
	sarrd_mode_t mode;
	logic signed [17:0] analog;
	logic ready;
	logic [15:0] data;
	logic data_valid;
	logic fault;
	logic [15:0] result;
	logic result_valid;
	logic sampling;
	logic chain_sel;
	logic busy_sel;
	int err_count;
	int tests_run;
	logic signed [17:0] corner [6] = '{18'sh07FFF, 18'sh00000,
		18'sh3FFFF, 18'sh38000, 18'sh1FFFF, 18'sh20000};
	sarrd_if i_sarrd_if ();
	sarrd_device i_sarrd_device (
		.i_mclk(mclk),
		.i_arst_n(arst_n),
		.i_analog(analog),
		.o_result(result),
		.o_result_valid(result_valid),
		.o_sampling(sampling),
		.o_chain_sel(chain_sel),
		.o_busy_sel(busy_sel),
		.lk(i_sarrd_if)
	);
	sarrd_host i_sarrd_host (
		.i_mclk(mclk),
		.i_arst_n(arst_n),
		.i_start(start),
		.i_mode(mode),
		.o_ready(ready),
		.o_data(data),
		.o_data_valid(data_valid),
		.o_fault(fault),
		.lk(i_sarrd_if)
	);
	sarrd_checker i_sarrd_checker (
		.i_mclk(mclk),
		.i_arst_n(arst_n),
		.conv_start(i_sarrd_if.conv_start),
		.ser_sel(i_sarrd_if.ser_sel),
		.ser_clk(i_sarrd_if.ser_clk),
		.ser_out(i_sarrd_if.ser_out),
		.ser_out_oe(i_sarrd_if.ser_out_oe)
	);
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Clamp to the two's complement 16-bit range
	function automatic logic [15:0] exp_code(logic signed [17:0] v);
		if (v > 18'sh07FFF)
			return 16'h7FFF;
		if (v < 18'sh38000)
			return 16'h8000;
		return v[15:0];
	endfunction
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic run(input sarrd_mode_t m, input logic signed [17:0] v);
		int n;
		n = 0;
		mode = m;
		analog = v;
		while (ready !== 1'b1 && n < 100)
		begin
			@(negedge mclk);
			n++;
		end
		chk1(ready, 1'b1);
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
		repeat (5) @(negedge mclk);
		chk1(sampling, 1'b0);
		n = 0;
		while (result_valid !== 1'b1 && n < 20)
		begin
			@(negedge mclk);
			n++;
		end
		chk1(result_valid, 1'b1);
		chk16(result, exp_code(v));
		n = 0;
		while (data_valid !== 1'b1 && n < 400)
		begin
			@(negedge mclk);
			n++;
		end
		chk1(data_valid, 1'b1);
		chk16(data, exp_code(v));
		chk16(result, exp_code(v));
		chk1(busy_sel, m == SARRD_3W_BUSY);
		chk1(chain_sel, 1'b0);
		chk1(fault, 1'b0);
		chk1(sampling, 1'b1);
		chk1(i_sarrd_if.ser_line, 1'b1);
		$display("test done mode=%0d code=%h", m, data);
	endtask
	initial
	begin
		start = 1'b0;
		mode = SARRD_3W_PLAIN;
		analog = 18'sh00000;
		err_count = 0;
		tests_run = 0;
		arst_n = 1'b0;
		void'($urandom(32'hFBCE));
		repeat (8) @(negedge mclk);
		arst_n = 1'b1;
		@(negedge mclk);
		for (int k = 0; k < 18; k++)
			run(sarrd_mode_t'(k % 3), corner[k / 3]);
		for (int k = 0; k < 6; k++)
			run(sarrd_mode_t'($urandom % 3), 18'($urandom));
		print_verdict();
	end
	initial
	begin
		#2000000;
		err_count++;
		print_verdict();
	end
endmodule // sar_adc_select_mode_readout_test
